// ===== design/fsr_status_regs.sv
// Flash control/status register slice with Wishbone slave and interrupt
// Notes on behaviour
// - Lock at 0x10, status at 0x20
// - Bits 25..16 show block protection
// - Programming a protected block is refused
// - Bit 0 low while auto operation runs
// - Bit 0 high after successful completion
// - Failure keeps bit 0 low until reset
// - Reset forces bit 0 to one
// - Busy command locks; reset recovers
// - Reads enabled about 2 ms after reset
// - Protection flags load from nonvolatile state
// - Lock bit 0 is security enable
// - Lock register reset only by cold reset
// - Full protection erase leaves status one
// - All protected inhibits program and erase
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none
module fsr_status_regs #(
    parameter int RECOV_CYCLES = fsr_pkg::RECOV_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cold_rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [fsr_pkg::WB_AW-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [fsr_pkg::WB_DW-1:0] wb_dat_i,
    output logic [fsr_pkg::WB_DW-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [fsr_pkg::NUM_BLOCKS-1:0] nv_protect_i,
    input wire logic op_start_i,
    input wire fsr_pkg::fsr_op_kind_t op_kind_i,
    input wire logic [fsr_pkg::BLK_W-1:0] op_block_i,
    input wire logic op_done_i,
    input wire logic op_fail_i,
    output logic op_accept_o,
    output logic op_refuse_o,
    output logic auto_op_done_flag_o,
    output logic read_enable_o,
    output logic security_enable_bit_o,
    output logic [fsr_pkg::NUM_BLOCKS-1:0] block_protect_flags_o,
    output logic irq_o
);
    import fsr_pkg::*;

    fsr_op_if op ();

    logic [NUM_BLOCKS-1:0] prot_q;
    logic load_pend_q;
    logic sec_q;
    logic [IRQ_W-1:0] irq_st_q;
    logic [IRQ_W-1:0] irq_mask_q;
    logic [IRQ_W-1:0] irq_ev;
    logic ack_q;
    logic [WB_DW-1:0] dat_q;
    logic irq_q;
    logic accept_q;
    logic refuse_q;
    fsr_op_kind_t kind_q;
    logic allow;
    logic req;
    logic wr;
    logic start_ok;
    logic busy_cmd;
    logic [WB_DW-1:0] clr_bits;

    function automatic logic [WB_DW-1:0] fsr_mask(input logic [WB_DW-1:0] d,
                                                  input logic [3:0] sel);
        logic [WB_DW-1:0] m;
        m = '0;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = sel[i] ? d[i*8 +: 8] : 8'h00;
        end
        return m;
    endfunction : fsr_mask

    function automatic logic [WB_DW-1:0] fsr_read(input logic [WB_AW-1:0] adr,
                                                  input logic [NUM_BLOCKS-1:0] prot,
                                                  input logic rdy,
                                                  input logic sec,
                                                  input logic [IRQ_W-1:0] st,
                                                  input logic [IRQ_W-1:0] mk,
                                                  input logic [2:0] ost);
        logic [WB_DW-1:0] r;
        r = '0;
        case (adr)
            OFF_SEC_LOCK: r[SEC_BIT] = sec;
            OFF_CTRL_STATUS: begin
                r[PROT_LSB +: NUM_BLOCKS] = prot;
                r[READY_BIT] = rdy;
            end
            OFF_IRQ_STATUS: r[IRQ_W-1:0] = st;
            OFF_IRQ_MASK: r[IRQ_W-1:0] = mk;
            OFF_OP_STATE: r[2:0] = ost;
            // Reserved and unmapped offsets answer with zero
            default: r = '0;
        endcase
        return r;
    endfunction : fsr_read

    assign req = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr = req && wb_we_i;
    assign busy_cmd = op_start_i && !op.ready;
    assign start_ok = op_start_i && op.ready && allow;
    // Byte-gated write-one-to-clear pattern
    assign clr_bits = fsr_mask(wb_dat_i, wb_sel_i);

    fsr_prot_gate #(
        .NUM_BLOCKS(NUM_BLOCKS)
    ) u_gate (
        .prot_i(prot_q),
        .kind_i(op_kind_i),
        .block_i(op_block_i),
        .allow_o(allow)
    );

    assign op.start = start_ok;
    assign op.done = op_done_i;
    assign op.fail = op_fail_i;
    assign op.cmd_busy = busy_cmd;

    fsr_busy_tracker #(
        .RECOV_CYCLES(RECOV_CYCLES)
    ) u_tracker (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .op(op)
    );

    // Wishbone answer one cycle after the request is seen
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= '0;
        end else begin
            ack_q <= req;
            if (req && !wb_we_i) begin
                dat_q <= fsr_read(wb_adr_i, prot_q, op.ready, sec_q, irq_st_q, irq_mask_q,
                                  {op.read_en, op.locked, op.failed});
            end
        end
    end

    // Lock survives system reset; only a cold reset reinitialises it
    always_ff @(posedge clk_i) begin
        if (cold_rst_i) begin
            sec_q <= SEC_RESET;
        end else if (wr && wb_adr_i == OFF_SEC_LOCK && wb_sel_i[0]) begin
            sec_q <= wb_dat_i[SEC_BIT];
        end
    end

    // Kind of the running operation, needed at completion
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            kind_q <= FSR_OP_PROG;
        end else if (start_ok) begin
            kind_q <= op_kind_i;
        end
    end

    // Flags come from the nonvolatile bits, caught after reset release;
    // host writes never reach them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prot_q <= '0;
            load_pend_q <= 1'b1;
        end else if (load_pend_q) begin
            prot_q <= nv_protect_i;
            load_pend_q <= 1'b0;
        end else if (op.ready == 1'b0 && op_done_i && !op_fail_i && !op.locked) begin
            if (kind_q == FSR_OP_PROT_ERASE && (&prot_q)) begin
                prot_q <= '0;
            end else begin
                prot_q <= nv_protect_i;
            end
        end
    end

    assign irq_ev[IRQ_DONE] = !op.ready && !op.failed && !op.locked && op_done_i && !op_fail_i;
    assign irq_ev[IRQ_FAIL] = !op.ready && !op.failed && !op.locked && op_fail_i;
    assign irq_ev[IRQ_LOCK] = busy_cmd;
    assign irq_ev[IRQ_REFUSE] = op_start_i && op.ready && !allow;

    // Sticky events: a new event beats a same-cycle write-one clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_st_q <= '0;
            irq_mask_q <= '0;
            irq_q <= 1'b0;
        end else begin
            if (wr && wb_adr_i == OFF_IRQ_STATUS) begin
                irq_st_q <= (irq_st_q & ~clr_bits[IRQ_W-1:0]) | irq_ev;
            end else begin
                irq_st_q <= irq_st_q | irq_ev;
            end
            if (wr && wb_adr_i == OFF_IRQ_MASK && wb_sel_i[0]) begin
                irq_mask_q <= wb_dat_i[IRQ_W-1:0];
            end
            irq_q <= |(irq_st_q & irq_mask_q);
        end
    end

    // Accept/refuse pulses toward the command sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            accept_q <= 1'b0;
            refuse_q <= 1'b0;
        end else begin
            accept_q <= start_ok;
            refuse_q <= op_start_i && !start_ok;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign op_accept_o = accept_q;
    assign op_refuse_o = refuse_q;
    assign auto_op_done_flag_o = op.ready;
    assign read_enable_o = op.read_en;
    assign security_enable_bit_o = sec_q;
    assign block_protect_flags_o = prot_q;
    assign irq_o = irq_q;

    a_refuse_protected: assert property (@(posedge clk_i) disable iff (rst_i)
        op_start_i && op_kind_i == FSR_OP_PROG && int'(op_block_i) < NUM_BLOCKS
        && prot_q[op_block_i] |=> !op_accept_o && op_refuse_o)
        else $error("program of protected block accepted");
    a_all_prot_inhibit: assert property (@(posedge clk_i) disable iff (rst_i)
        op_start_i && (&prot_q) && op_kind_i inside {FSR_OP_PROG, FSR_OP_BLK_ERASE,
        FSR_OP_CHIP_ERASE} |=> !op_accept_o)
        else $error("operation accepted with all blocks protected");
    a_status_zero_bits: assert property (@(posedge clk_i) disable iff (rst_i)
        req && !wb_we_i && wb_adr_i == OFF_CTRL_STATUS
        |=> wb_ack_o && wb_dat_o[31:26] == 6'h00 && wb_dat_o[15:1] == 15'h0000
        && wb_dat_o[PROT_LSB +: NUM_BLOCKS] == $past(prot_q))
        else $error("status read shows wrong bits");
    a_sec_upper_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        req && !wb_we_i && wb_adr_i == OFF_SEC_LOCK
        |=> wb_dat_o[31:1] == 31'h00000000 && wb_dat_o[SEC_BIT] == $past(sec_q))
        else $error("lock register read wrong");
    a_flags_nv_load: assert property (@(posedge clk_i) disable iff (rst_i)
        load_pend_q |=> prot_q == $past(nv_protect_i))
        else $error("protection flags not loaded from nonvolatile state");
    a_flags_no_write: assert property (@(posedge clk_i) disable iff (rst_i)
        !load_pend_q && !op_done_i |=> $stable(prot_q))
        else $error("protection flags changed without operation");
endmodule : fsr_status_regs
`default_nettype wire

// ===== design/fsr_pkg.sv
// Shared constants and types for the flash status register slice
`default_nettype none
package fsr_pkg;
    localparam int WB_AW = 8;
    localparam int WB_DW = 32;
    localparam logic [WB_AW-1:0] OFF_SEC_LOCK = 8'h10;
    localparam logic [WB_AW-1:0] OFF_CTRL_STATUS = 8'h20;
    localparam logic [WB_AW-1:0] OFF_IRQ_STATUS = 8'h30;
    localparam logic [WB_AW-1:0] OFF_IRQ_MASK = 8'h34;
    localparam logic [WB_AW-1:0] OFF_OP_STATE = 8'h38;
    localparam int NUM_BLOCKS = 10;
    localparam int BLK_W = 4;
    localparam int PROT_LSB = 16;
    localparam int READY_BIT = 0;
    localparam int SEC_BIT = 0;
    localparam logic SEC_RESET = 1'b1;
    localparam logic READY_RESET = 1'b1;
    localparam int IRQ_W = 4;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_FAIL = 1;
    localparam int IRQ_LOCK = 2;
    localparam int IRQ_REFUSE = 3;
    localparam int ST_FAILED_BIT = 0;
    localparam int ST_LOCKED_BIT = 1;
    localparam int ST_READ_EN_BIT = 2;
    localparam int CLK_MHZ = 25;
    localparam int CLK_PERIOD_NS = 40;
    localparam int RECOV_TIME_US = 2000;
    localparam int RECOV_CYCLES = RECOV_TIME_US * CLK_MHZ;
    localparam int SYS_RST_MIN_NS = 500;
    localparam int SYS_RST_MIN_CYCLES = (SYS_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    typedef enum logic [2:0] {
        FSR_OP_PROG,
        FSR_OP_BLK_ERASE,
        FSR_OP_CHIP_ERASE,
        FSR_OP_PROT_PROG,
        FSR_OP_PROT_ERASE
    } fsr_op_kind_t;
    typedef enum logic [1:0] {
        FSR_ST_READY,
        FSR_ST_BUSY,
        FSR_ST_FAILED,
        FSR_ST_LOCKED
    } fsr_state_t;
endpackage : fsr_pkg
`default_nettype wire

// ===== design/fsr_op_if.sv
// Operation handshake between the register slice and its busy tracker
`timescale 1ns/1ns
`default_nettype none
interface fsr_op_if;
    logic start;
    logic done;
    logic fail;
    logic cmd_busy;
    logic ready;
    logic failed;
    logic locked;
    logic read_en;
    modport tracker (
        input start, done, fail, cmd_busy,
        output ready, failed, locked, read_en
    );
    modport ctrl (
        output start, done, fail, cmd_busy,
        input ready, failed, locked, read_en
    );
endinterface : fsr_op_if
`default_nettype wire

// ===== design/fsr_busy_tracker.sv
// Ready/busy state of automatic operations and read recovery timer
`timescale 1ns/1ns
`default_nettype none
module fsr_busy_tracker #(
    parameter int RECOV_CYCLES = fsr_pkg::RECOV_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    fsr_op_if.tracker op
);
    import fsr_pkg::*;
    localparam int CNT_W = $clog2(RECOV_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(RECOV_CYCLES);

    fsr_state_t state_q;
    fsr_state_t state_d;
    logic ready_q;
    logic read_en_q;
    logic [CNT_W-1:0] cnt_q;

    always_comb begin
        state_d = state_q;
        case (state_q)
            FSR_ST_READY: begin
                if (op.start) begin
                    state_d = FSR_ST_BUSY;
                end
            end
            FSR_ST_BUSY: begin
                if (op.cmd_busy) begin
                    state_d = FSR_ST_LOCKED;
                end else if (op.fail) begin
                    state_d = FSR_ST_FAILED;
                end else if (op.done) begin
                    state_d = FSR_ST_READY;
                end
            end
            // Only a reset leaves these two
            FSR_ST_FAILED: state_d = FSR_ST_FAILED;
            FSR_ST_LOCKED: state_d = FSR_ST_LOCKED;
            default: state_d = FSR_ST_READY;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= FSR_ST_READY;
            ready_q <= READY_RESET;
        end else begin
            state_q <= state_d;
            ready_q <= (state_d == FSR_ST_READY);
        end
    end

    // Reads stay off while the array recovers from reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= CNT_LOAD;
            read_en_q <= 1'b0;
        end else begin
            if (cnt_q != '0) begin
                cnt_q <= cnt_q - 1'b1;
            end
            read_en_q <= (cnt_q == '0);
        end
    end

    assign op.ready = ready_q;
    assign op.failed = (state_q == FSR_ST_FAILED);
    assign op.locked = (state_q == FSR_ST_LOCKED);
    assign op.read_en = read_en_q;

    a_busy_on_start: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_q == FSR_ST_READY) && op.start |=> !ready_q [*2])
        else $error("ready did not fall on operation start");
    a_done_sets_ready: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_q == FSR_ST_BUSY) && op.done && !op.fail && !op.cmd_busy |=> ready_q)
        else $error("ready not restored after good completion");
    a_fail_sticks: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_q == FSR_ST_BUSY) && op.fail && !op.cmd_busy |=> !ready_q [*8])
        else $error("ready came back after a failed operation");
    a_ready_after_reset: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(rst_i) |-> ready_q)
        else $error("ready not one after reset");
    a_lock_on_busy_cmd: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_q == FSR_ST_BUSY) && op.cmd_busy |=> op.locked && !ready_q)
        else $error("command while busy did not lock");
    a_recov_reads_off: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(rst_i) |-> !read_en_q [*8])
        else $error("reads enabled too soon after reset");
endmodule : fsr_busy_tracker
`default_nettype wire

// ===== design/fsr_prot_gate.sv
// Decides whether a requested operation may touch the array
`timescale 1ns/1ns
`default_nettype none
module fsr_prot_gate #(
    parameter int NUM_BLOCKS = fsr_pkg::NUM_BLOCKS
) (
    input wire logic [NUM_BLOCKS-1:0] prot_i,
    input wire fsr_pkg::fsr_op_kind_t kind_i,
    input wire logic [fsr_pkg::BLK_W-1:0] block_i,
    output logic allow_o
);
    import fsr_pkg::*;
    logic blk_prot;
    logic all_prot;

    // Out-of-range block numbers count as protected
    assign blk_prot = (int'(block_i) < NUM_BLOCKS) ? prot_i[block_i] : 1'b1;
    assign all_prot = &prot_i;

    always_comb begin
        case (kind_i)
            FSR_OP_PROG: allow_o = !blk_prot && !all_prot;
            FSR_OP_BLK_ERASE: allow_o = !blk_prot && !all_prot;
            FSR_OP_CHIP_ERASE: allow_o = !all_prot;
            FSR_OP_PROT_PROG: allow_o = 1'b1;
            FSR_OP_PROT_ERASE: allow_o = 1'b1;
            default: allow_o = 1'b0;
        endcase
    end
endmodule : fsr_prot_gate
`default_nettype wire

// ===== verif/fsr_engine_model.sv
// Behavioural model of the program/erase engine and its nonvolatile protect bits
`timescale 1ns/1ns
`default_nettype none
module fsr_engine_model (
    input wire logic clk_i,
    input wire logic accept_i,
    input wire fsr_pkg::fsr_op_kind_t kind_i,
    input wire logic [fsr_pkg::BLK_W-1:0] block_i,
    input wire logic [7:0] delay_i,
    input wire logic fail_cmd_i,
    output logic done_o,
    output logic fail_o,
    output logic [fsr_pkg::NUM_BLOCKS-1:0] nv_protect_o
);
    import fsr_pkg::*;
    logic busy_q = 1'b0;
    logic [7:0] cnt_q = 8'h00;
    fsr_op_kind_t kind_q = FSR_OP_PROG;
    logic [BLK_W-1:0] blk_q = '0;
    // Nonvolatile state survives every reset, so it has no reset branch
    initial begin
        done_o = 1'b0;
        fail_o = 1'b0;
        nv_protect_o = 10'h005;
    end
    always @(posedge clk_i) begin
        done_o <= 1'b0;
        fail_o <= 1'b0;
        if (accept_i) begin
            busy_q <= 1'b1;
            cnt_q <= delay_i;
            kind_q <= kind_i;
            blk_q <= block_i;
        end else if (busy_q && cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
        end else if (busy_q) begin
            busy_q <= 1'b0;
            // Exactly one of done or fail ends each operation; fail only on command
            fail_o <= fail_cmd_i;
            done_o <= !fail_cmd_i;
            if (!fail_cmd_i && kind_q == FSR_OP_PROT_PROG && blk_q < 4'hA) begin
                nv_protect_o[blk_q] <= 1'b1;
            end
            if (!fail_cmd_i && kind_q == FSR_OP_PROT_ERASE) begin
                nv_protect_o <= '0;
            end
        end
    end
endmodule : fsr_engine_model
`default_nettype wire

// ===== verif/fsr_status_regs_tb.sv
// Self-checking bench for the flash status register slice
`timescale 1ns/1ns
`default_nettype none
module fsr_status_regs_tb;
    import fsr_pkg::*;
    localparam int RECOV = 20;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cold_rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [WB_AW-1:0] wb_adr_i = '0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [WB_DW-1:0] wb_dat_i = '0;
    logic [WB_DW-1:0] wb_dat_o;
    logic wb_ack_o;
    logic op_start_i = 1'b0;
    fsr_op_kind_t op_kind_i = FSR_OP_PROG;
    logic [BLK_W-1:0] op_block_i = '0;
    logic [NUM_BLOCKS-1:0] nv_protect, flags_o;
    logic op_done, op_fail, op_accept_o, op_refuse_o, ready_o, read_en_o, sec_o, irq_o;
    logic [7:0] delay = 8'h1E;
    logic fail_cmd = 1'b0;
    int err_count = 0;
    int samples_checked = 0;
    logic [31:0] rd;
    logic acc, rfs;
    logic [7:0] unmapped [4] = '{8'h08, 8'h0C, 8'h14, 8'h3C};
    fsr_op_kind_t denied [3] = '{FSR_OP_PROG, FSR_OP_BLK_ERASE, FSR_OP_CHIP_ERASE};

    fsr_status_regs #(.RECOV_CYCLES(RECOV)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .cold_rst_i(cold_rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .nv_protect_i(nv_protect), .op_start_i(op_start_i), .op_kind_i(op_kind_i),
        .op_block_i(op_block_i), .op_done_i(op_done), .op_fail_i(op_fail),
        .op_accept_o(op_accept_o), .op_refuse_o(op_refuse_o), .auto_op_done_flag_o(ready_o),
        .read_enable_o(read_en_o), .security_enable_bit_o(sec_o),
        .block_protect_flags_o(flags_o), .irq_o(irq_o)
    );
    fsr_engine_model i_engine (
        .clk_i(clk_i), .accept_i(op_accept_o), .kind_i(op_kind_i), .block_i(op_block_i),
        .delay_i(delay), .fail_cmd_i(fail_cmd), .done_o(op_done), .fail_o(op_fail),
        .nv_protect_o(nv_protect)
    );

    initial begin
        forever #20 clk_i = ~clk_i;
    end

    task automatic summarize;
        $display("Comparisons %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize

    task automatic give_up;
        err_count++;
        $display("[FAIL] t=%0t timeout got=%h exp=%h", $time, 1'b0, 1'b1);
        summarize();
    endtask : give_up

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask : tick

    // Request held until ack is sampled high at a rising edge, released at that edge
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        wb_sel_i <= 4'hF;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1) give_up();
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask : wb_xfer

    task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
        wb_xfer(1'b1, adr, wd);
    endtask : wr

    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
        wb_xfer(1'b0, adr, 32'h0);
        cmp(rd, exp);
    endtask : rd_chk

    task automatic start_op(input fsr_op_kind_t k, input logic [3:0] b);
        @(posedge clk_i);
        op_start_i <= 1'b1;
        op_kind_i <= k;
        op_block_i <= b;
        @(posedge clk_i);
        op_start_i <= 1'b0;
        @(negedge clk_i);
        acc = op_accept_o;
        rfs = op_refuse_o;
    endtask : start_op

    task automatic wait_ready;
        int n;
        n = 0;
        while (ready_o !== 1'b1) begin
            @(negedge clk_i);
            n++;
            if (n > 400) give_up();
        end
    endtask : wait_ready

    task automatic sys_reset(input logic cold, input int cyc);
        @(posedge clk_i);
        rst_i <= 1'b1;
        cold_rst_i <= cold;
        repeat (cyc) @(posedge clk_i);
        rst_i <= 1'b0;
        cold_rst_i <= 1'b0;
        tick(2);
    endtask : sys_reset

    initial begin
        repeat (100000) @(posedge clk_i);
        give_up();
    end

    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        cold_rst_i <= 1'b0;
        tick(2);
        cmp({31'h0, read_en_o}, 32'h0);
        rd_chk(OFF_CTRL_STATUS, 32'h0005_0001);
        rd_chk(OFF_SEC_LOCK, 32'h0000_0001);
        tick(RECOV);
        cmp({31'h0, read_en_o}, 32'h1);
        $display("Test reset values done");
        wr(OFF_CTRL_STATUS, 32'hFFFF_FFFF);
        rd_chk(OFF_CTRL_STATUS, 32'h0005_0001);
        wr(OFF_SEC_LOCK, 32'hFFFF_FFFE);
        rd_chk(OFF_SEC_LOCK, 32'h0000_0000);
        cmp({31'h0, sec_o}, 32'h0);
        wr(OFF_SEC_LOCK, 32'hFFFF_FFFF);
        rd_chk(OFF_SEC_LOCK, 32'h0000_0001);
        // Unmapped holes are written with all ones and must still read zero
        foreach (unmapped[i]) begin
            wr(unmapped[i], 32'hFFFF_FFFF);
            rd_chk(unmapped[i], 32'h0000_0000);
        end
        $display("Test register access done");
        start_op(FSR_OP_PROG, 4'h0);
        cmp({30'h0, acc, rfs}, 32'h1);
        cmp({31'h0, ready_o}, 32'h1);
        start_op(FSR_OP_PROG, 4'h1);
        cmp({30'h0, acc, rfs}, 32'h2);
        rd_chk(OFF_CTRL_STATUS, 32'h0005_0000);
        wait_ready();
        rd_chk(OFF_CTRL_STATUS, 32'h0005_0001);
        rd_chk(OFF_IRQ_STATUS, 32'h0000_0009);
        cmp({31'h0, irq_o}, 32'h0);
        wr(OFF_IRQ_MASK, 32'h0000_0001);
        rd_chk(OFF_IRQ_MASK, 32'h0000_0001);
        tick(2);
        cmp({31'h0, irq_o}, 32'h1);
        wr(OFF_IRQ_STATUS, 32'h0000_0009);
        tick(2);
        cmp({31'h0, irq_o}, 32'h0);
        rd_chk(OFF_IRQ_STATUS, 32'h0000_0000);
        $display("Test program and interrupt done");
        delay <= 8'h01;
        for (int b = 1; b < 10; b++) begin
            if (b != 2) begin
                start_op(FSR_OP_PROT_PROG, b[3:0]);
                wait_ready();
            end
        end
        cmp({22'h0, flags_o}, 32'h0000_03FF);
        rd_chk(OFF_CTRL_STATUS, 32'h03FF_0001);
        foreach (denied[i]) begin
            start_op(denied[i], 4'h5);
            cmp({30'h0, acc, rfs}, 32'h1);
        end
        start_op(FSR_OP_PROT_ERASE, 4'h0);
        wait_ready();
        rd_chk(OFF_CTRL_STATUS, 32'h0000_0001);
        $display("Test full protection done");
        wr(OFF_SEC_LOCK, 32'h0000_0000);
        wr(OFF_IRQ_STATUS, 32'h0000_000F);
        fail_cmd <= 1'b1;
        start_op(FSR_OP_BLK_ERASE, 4'h3);
        tick(60);
        rd_chk(OFF_CTRL_STATUS, 32'h0000_0000);
        rd_chk(OFF_IRQ_STATUS, 32'h0000_0002);
        rd_chk(OFF_OP_STATE, 32'h0000_0005);
        fail_cmd <= 1'b0;
        sys_reset(1'b0, 13);
        rd_chk(OFF_CTRL_STATUS, 32'h0000_0001);
        rd_chk(OFF_SEC_LOCK, 32'h0000_0000);
        $display("Test failed operation done");
        delay <= 8'h14;
        start_op(FSR_OP_PROG, 4'h4);
        start_op(FSR_OP_PROG, 4'h6);
        cmp({30'h0, acc, rfs}, 32'h1);
        tick(40);
        rd_chk(OFF_CTRL_STATUS, 32'h0000_0000);
        wb_xfer(1'b0, OFF_IRQ_STATUS, 32'h0);
        cmp(rd & 32'h0000_0004, 32'h0000_0004);
        rd_chk(OFF_OP_STATE, 32'h0000_0006);
        sys_reset(1'b1, 13);
        rd_chk(OFF_CTRL_STATUS, 32'h0000_0001);
        rd_chk(OFF_SEC_LOCK, 32'h0000_0001);
        $display("Test busy command recovery done");
        summarize();
    end
endmodule : fsr_status_regs_tb
`default_nettype wire
